// [hw/lnbc_device.sv]
// device end: output enable, hiccup and thermal supervision, fault pin, tone gate and detector
`timescale 1ns/1ps
module lnbc_device
	import lnbc_pkg::*;
#(
	parameter int ON_SHORT_TICKS = LNBC_ON_SHORT_TICKS,
	parameter int ON_LONG_TICKS = LNBC_ON_LONG_TICKS,
	parameter int OFF_SHORT_TICKS = LNBC_OFF_SHORT_TICKS,
	parameter int OFF_LONG_TICKS = LNBC_OFF_LONG_TICKS,
	parameter int TICK_CYC = LNBC_TICK_CYC
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	lnbc_if.dev lnk,
	input wire logic overcurrent_in,
	input wire logic temp_high_in,
	input wire logic temp_low_in,
	input wire logic output_voltage_ok_in,
	input wire logic detect_in,
	output logic dish_supply_on,
	output logic tone_drive,
	output logic switch_limit_scale_sel
);
	// the prescaler is 12 bits and the hiccup counter 16 bits wide; larger counts would wrap
	if (ON_SHORT_TICKS < 1 || ON_LONG_TICKS < 1 || OFF_SHORT_TICKS < 1 || OFF_LONG_TICKS < 1 || TICK_CYC < 1 ||
		TICK_CYC > 4096 || ON_SHORT_TICKS > 65535 || ON_LONG_TICKS > 65535 || OFF_SHORT_TICKS > 65535 ||
		OFF_LONG_TICKS > 65535) begin : g_bad_counts
		$error("lnbc_device: hiccup or tick counts out of range");
	end
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [6:0] meta_r;
	logic [6:0] sync_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= 7'h00;
			sync_r <= 7'h00;
		end else begin
			meta_r <= {lnk.enable_pin, lnk.tone_gate_pin, overcurrent_in, temp_high_in, temp_low_in, detect_in,
				output_voltage_ok_in};
			sync_r <= meta_r;
		end
	end
	logic en_pin_s, gate_s, oc_s, th_s, tl_s, det_s, vok_s;
	assign {en_pin_s, gate_s, oc_s, th_s, tl_s, det_s, vok_s} = sync_r;
	logic en_pin_d_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) en_pin_d_r <= 1'b0;
		else en_pin_d_r <= en_pin_s;
	end
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] ctl1_r;
	logic [7:0] ctl2_r;
	logic [7:0] rdata_r;
	logic fault_r;
	logic oc_flag_r;
	logic th_flag_r;
	logic tone_seen_r;
	// registers take writes whatever the enable pin or protection state
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl1_r <= LNBC_C1_RESET;
			ctl2_r <= LNBC_S2_RESET;
		end else if (lnk.wr) begin
			if (lnk.addr == LNBC_ADDR_CONTROL_ONE) ctl1_r <= lnk.wdata & LNBC_C1_WMASK;
			if (lnk.addr == LNBC_ADDR_STATUS_CONTROL_TWO) ctl2_r <= lnk.wdata & LNBC_S2_WMASK;
		end
	end
	logic bus_ctl, hic_long;
	assign bus_ctl = ctl1_r[LNBC_C1_BUS_CONTROL_SELECT];
	assign hic_long = ctl1_r[LNBC_C1_HICCUP_LONG];
	assign switch_limit_scale_sel = ctl1_r[LNBC_C1_SWITCH_LIMIT_SCALE_SEL];
	// read data: one cycle after the strobe, unmapped reads give zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) rdata_r <= 8'h00;
		else if (lnk.rd) begin
			unique case (lnk.addr)
				LNBC_ADDR_CONTROL_ONE: rdata_r <= ctl1_r;
				LNBC_ADDR_STATUS_CONTROL_TWO: begin
					rdata_r <= ctl2_r;
					rdata_r[LNBC_S2_OUTPUT_VOLTAGE_OK_FLAG] <= vok_s;
					rdata_r[LNBC_S2_OVERCURRENT] <= oc_flag_r;
					rdata_r[LNBC_S2_THERMAL] <= th_flag_r;
					rdata_r[LNBC_S2_FAULT] <= fault_r;
					rdata_r[LNBC_S2_TONE_SEEN] <= tone_seen_r;
				end
				default: rdata_r <= 8'h00;
			endcase
		end else rdata_r <= 8'h00;
	end
	assign lnk.rdata = rdata_r;
	// ----------------------------------------------------------------
	// output enable selection
	// ----------------------------------------------------------------
	logic want_on;
	assign want_on = bus_ctl ? ctl2_r[LNBC_S2_OUTPUT_ENABLE] : en_pin_s;
	// ----------------------------------------------------------------
	// hiccup timing
	// ----------------------------------------------------------------
	logic [11:0] pre_r;
	logic tick;
	assign tick = (pre_r == 12'(TICK_CYC - 1));
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) pre_r <= 12'h000;
		else pre_r <= tick ? 12'h000 : pre_r + 12'h001;
	end
	lnbc_hic_e hic_r;
	logic [15:0] hcnt_r;
	logic [15:0] on_lim, off_lim;
	assign on_lim = 16'(hic_long ? ON_LONG_TICKS : ON_SHORT_TICKS);
	assign off_lim = 16'(hic_long ? OFF_LONG_TICKS : OFF_SHORT_TICKS);
	logic oc_event;
	assign oc_event = (hic_r == LNBC_RUN) && oc_s && want_on;
	// counters step on the reference tick
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			hic_r <= LNBC_RUN;
			hcnt_r <= 16'h0000;
		end else begin
			unique case (hic_r)
				LNBC_RUN: begin
					hcnt_r <= 16'h0000;
					if (oc_event) hic_r <= LNBC_CLAMP;
				end
				LNBC_CLAMP: begin
					if (!oc_s) begin
						hic_r <= LNBC_RUN;
					end else if (tick) begin
						if (hcnt_r + 16'h0001 >= on_lim) begin
							hic_r <= LNBC_OFF;
							hcnt_r <= 16'h0000;
						end else hcnt_r <= hcnt_r + 16'h0001;
					end
				end
				LNBC_OFF: begin
					if (tick) begin
						if (hcnt_r + 16'h0001 >= off_lim) begin
							hic_r <= LNBC_RUN; // automatic restart
							hcnt_r <= 16'h0000;
						end else hcnt_r <= hcnt_r + 16'h0001;
					end
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// thermal shutdown with hysteresis
	// ----------------------------------------------------------------
	logic hot_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) hot_r <= 1'b0;
		else if (th_s) hot_r <= 1'b1;
		else if (!tl_s) hot_r <= 1'b0;
	end
	logic hot_rise;
	logic hot_d_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) hot_d_r <= 1'b0;
		else hot_d_r <= hot_r;
	end
	assign hot_rise = hot_r && !hot_d_r;
	// registered so the supply switch never sees a glitch while its terms settle
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) dish_supply_on <= 1'b0;
		else dish_supply_on <= want_on && !hot_r && (hic_r != LNBC_OFF);
	end
	// ----------------------------------------------------------------
	// sticky fault latch; set wins over clear
	// ----------------------------------------------------------------
	logic clr_pin, clr_read;
	assign clr_pin = !bus_ctl && en_pin_s && !en_pin_d_r;
	assign clr_read = lnk.rd && (lnk.addr == LNBC_ADDR_STATUS_CONTROL_TWO);
	logic cyc_low_r;
	// the pin clear needs a full low-then-high cycle seen after the fault
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) cyc_low_r <= 1'b0;
		else if (oc_event || hot_rise) cyc_low_r <= 1'b0;
		else if (!en_pin_s) cyc_low_r <= 1'b1;
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) fault_r <= 1'b0;
		else if (oc_event || hot_rise) fault_r <= 1'b1;
		else if ((clr_pin && cyc_low_r) || clr_read) fault_r <= 1'b0;
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			oc_flag_r <= 1'b0;
			th_flag_r <= 1'b0;
		end else begin
			oc_flag_r <= oc_event ? 1'b1 : (clr_read ? 1'b0 : oc_flag_r);
			th_flag_r <= hot_rise ? 1'b1 : (clr_read ? 1'b0 : th_flag_r);
		end
	end
	assign lnk.fault_n_o = 1'b0;
	assign lnk.fault_n_oe_n = !fault_r;
	// ----------------------------------------------------------------
	// tone generation
	// ----------------------------------------------------------------
	logic [9:0] tdiv_r;
	logic tone_int_r;
	// internal 22 kHz square wave, gated by the tone pin level
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tdiv_r <= 10'h000;
			tone_int_r <= 1'b0;
		end else if (tdiv_r == 10'(LNBC_TONE_HALF_CYC - 1)) begin
			tdiv_r <= 10'h000;
			tone_int_r <= !tone_int_r;
		end else tdiv_r <= tdiv_r + 10'h001;
	end
	// a toggling gate pin is an external carrier: track edges to tell it from an envelope
	logic gate_d_r;
	logic [10:0] since_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			gate_d_r <= 1'b0;
			since_r <= 11'h7FF;
		end else begin
			gate_d_r <= gate_s;
			if (gate_s != gate_d_r) since_r <= 11'h000;
			else if (since_r != 11'h7FF) since_r <= since_r + 11'h001;
		end
	end
	logic ext_clk;
	assign ext_clk = (since_r < 11'(LNBC_TONE_PERIOD_CYC));
	// external 22/44 kHz reproduced as is; double rate allowed only when selected
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) tone_drive <= 1'b0;
		else if (ext_clk && (ctl1_r[LNBC_C1_DOUBLE_RATE_TONE_SEL] || since_r > 11'(LNBC_TONE_HALF_CYC / 2)))
			tone_drive <= gate_s && dish_supply_on;
		else if (ext_clk) tone_drive <= tone_drive;
		else tone_drive <= gate_s && tone_int_r && dish_supply_on;
	end
	// ----------------------------------------------------------------
	// tone detector: any edge within 1.5 periods means tone present
	// ----------------------------------------------------------------
	logic det_d_r;
	logic [11:0] dcnt_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			det_d_r <= 1'b0;
			dcnt_r <= 12'h000;
			tone_seen_r <= 1'b0;
		end else begin
			det_d_r <= det_s;
			if (det_s != det_d_r) begin
				dcnt_r <= 12'(LNBC_DET_WINDOW_CYC);
				tone_seen_r <= 1'b1;
			end else if (dcnt_r != 12'h000) dcnt_r <= dcnt_r - 12'h001;
			else tone_seen_r <= 1'b0;
		end
	end
	assign lnk.detect_n_o = 1'b0;
	assign lnk.detect_n_oe_n = !tone_seen_r;
endmodule : lnbc_device

// [common/lnbc_pkg.sv]
// package with shared constants of the dish supply control and fault logic
// Function
// - switch limit scale bit selects 3x or 5x
// - overcurrent: stay clamped for on-time 29/58 ms
// - persisting overcurrent: off 233/466 ms, then retry
// - hiccup timing pair chosen by control bit
// - over-temperature off, back on when cooled
// - registers and logic live during protection
// - protection event pulls fault output low, holds
// - no bus control: enable pin cycle clears fault
// - bus control: status register read clears fault
// - tone gate high superimposes internal tone
// - external 22 kHz clock on gate reproduced
// - double-rate bit with 44 kHz input gives 44 kHz
// - detector pulls output low while tone present
// - detector follows within 1.5 tone periods
// - software leaves detector mode bit at default
// - pin control: enable pin high enables output
// - registers reachable whatever the enable pin
// - bus control bit set: enable from register bit
// - bus control bit resets to zero
// - output voltage good flag in status bit 0
// - bus control select is bit 7 of 0x01
// - register enable bit resets to one
package lnbc_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] LNBC_ADDR_CONTROL_ONE = 8'h01;
	localparam logic [7:0] LNBC_ADDR_STATUS_CONTROL_TWO = 8'h02;
	// control_one fields
	localparam int LNBC_C1_BUS_CONTROL_SELECT = 7;
	localparam int LNBC_C1_HICCUP_LONG = 6;
	localparam int LNBC_C1_SWITCH_LIMIT_SCALE_SEL = 5;
	localparam int LNBC_C1_DOUBLE_RATE_TONE_SEL = 4;
	localparam logic [7:0] LNBC_C1_RESET = 8'h00;
	localparam logic [7:0] LNBC_C1_WMASK = 8'hF0;
	// status_control_two fields
	localparam int LNBC_S2_OUTPUT_VOLTAGE_OK_FLAG = 0;
	localparam int LNBC_S2_OVERCURRENT = 1;
	localparam int LNBC_S2_THERMAL = 2;
	localparam int LNBC_S2_FAULT = 3;
	localparam int LNBC_S2_TONE_SEEN = 4;
	localparam int LNBC_S2_DETECT_OUT_MODE_RSVD = 6;
	localparam int LNBC_S2_OUTPUT_ENABLE = 7;
	localparam logic [7:0] LNBC_S2_RESET = 8'h80;
	localparam logic [7:0] LNBC_S2_WMASK = 8'hC0;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int LNBC_CLK_HZ = 40_000_000;
	localparam int LNBC_TICK_US = 100; // reference tick for hiccup counters
	localparam int LNBC_TICK_CYC = LNBC_CLK_HZ / 1_000_000 * LNBC_TICK_US;
	localparam int LNBC_ON_SHORT_MS = 29;
	localparam int LNBC_ON_LONG_MS = 58;
	localparam int LNBC_OFF_SHORT_MS = 233;
	localparam int LNBC_OFF_LONG_MS = 466;
	localparam int LNBC_ON_SHORT_TICKS = LNBC_ON_SHORT_MS * 1000 / LNBC_TICK_US;
	localparam int LNBC_ON_LONG_TICKS = LNBC_ON_LONG_MS * 1000 / LNBC_TICK_US;
	localparam int LNBC_OFF_SHORT_TICKS = LNBC_OFF_SHORT_MS * 1000 / LNBC_TICK_US;
	localparam int LNBC_OFF_LONG_TICKS = LNBC_OFF_LONG_MS * 1000 / LNBC_TICK_US;
	localparam int LNBC_TONE_HZ = 22_000;
	localparam int LNBC_TONE_HALF_CYC = LNBC_CLK_HZ / (2 * LNBC_TONE_HZ);
	// tone period in cycles; detector window is 1.5 periods, rounded down
	localparam int LNBC_TONE_PERIOD_CYC = LNBC_CLK_HZ / LNBC_TONE_HZ;
	localparam int LNBC_DET_WINDOW_CYC = LNBC_CLK_HZ * 3 / (2 * LNBC_TONE_HZ);
	typedef enum logic [1:0] {LNBC_RUN, LNBC_CLAMP, LNBC_OFF} lnbc_hic_e;
endpackage : lnbc_pkg

// [common/lnbc_if.sv]
// interface joining the supply device and its host controller
`timescale 1ns/1ps
interface lnbc_if;
	logic enable_pin;
	logic tone_gate_pin;
	logic fault_n_o;
	logic fault_n_oe_n;
	logic detect_n_o;
	logic detect_n_oe_n;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	modport dev (input enable_pin, input tone_gate_pin, output fault_n_o, output fault_n_oe_n,
		output detect_n_o, output detect_n_oe_n, input addr, input wdata, input wr, input rd, output rdata);
	modport host (output enable_pin, output tone_gate_pin, input fault_n_o, input fault_n_oe_n,
		input detect_n_o, input detect_n_oe_n, output addr, output wdata, output wr, output rd, input rdata);
endinterface : lnbc_if

// [hw/lnbc_host.sv]
// host end: drives enable and tone pins, runs register accesses, watches fault and detect pins
`timescale 1ns/1ps
module lnbc_host
	import lnbc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	lnbc_if.host lnk,
	input wire logic user_enable,
	input wire logic user_tone,
	input wire logic [7:0] user_addr,
	input wire logic [7:0] user_wdata,
	input wire logic user_wr,
	input wire logic user_rd,
	output logic [7:0] user_rdata,
	output logic fault_seen,
	output logic tone_present
);
	// ----------------------------------------------------------------
	// pin drive and register access pass-through
	// ----------------------------------------------------------------
	logic en_r, tone_r;
	logic [7:0] addr_r, wdata_r;
	logic wr_r, rd_r;
	// pins change right after the edge; user cycles enable low then high to clear
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			en_r <= 1'b0;
			tone_r <= 1'b0;
			addr_r <= 8'h00;
			wdata_r <= 8'h00;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
		end else begin
			en_r <= user_enable;
			tone_r <= user_tone;
			addr_r <= user_addr;
			wdata_r <= (user_addr == LNBC_ADDR_STATUS_CONTROL_TWO) ? (user_wdata & ~(8'h01 << LNBC_S2_DETECT_OUT_MODE_RSVD))
				: user_wdata;
			wr_r <= user_wr && !user_rd;
			rd_r <= user_rd;
		end
	end
	assign lnk.enable_pin = en_r;
	assign lnk.tone_gate_pin = tone_r;
	assign lnk.addr = addr_r;
	assign lnk.wdata = wdata_r;
	assign lnk.wr = wr_r;
	assign lnk.rd = rd_r;
	// ----------------------------------------------------------------
	// status back to the user
	// ----------------------------------------------------------------
	logic [1:0] fmeta_r, fsync_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fmeta_r <= 2'h0;
			fsync_r <= 2'h0;
			user_rdata <= 8'h00;
		end else begin
			fmeta_r <= {lnk.fault_n_oe_n ? 1'b0 : !lnk.fault_n_o, lnk.detect_n_oe_n ? 1'b0 : !lnk.detect_n_o};
			fsync_r <= fmeta_r;
			user_rdata <= lnk.rdata;
		end
	end
	assign fault_seen = fsync_r[1];
	assign tone_present = fsync_r[0];
endmodule : lnbc_host

// [sim/lnbc_asserts.sv]
// checker watching the interface between the supply device and its host
`timescale 1ns/1ps
module lnbc_asserts (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic enable_pin,
	input wire logic fault_n_o,
	input wire logic fault_n_oe_n,
	input wire logic detect_n_o,
	input wire logic detect_n_oe_n,
	input wire logic [7:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// ----------------------------------------------------------------
	// helper logic
	// ----------------------------------------------------------------
	// a read of the status register, the one access that clears the fault
	logic status_rd;
	logic [3:0] en_age_r;
	assign status_rd = rd && (addr == 8'h02);
	// cycles since the enable pin rose; saturates so an old rise never looks fresh
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			en_age_r <= 4'hF;
		end else if ($rose(enable_pin)) begin
			en_age_r <= 4'h0;
		end else if (en_age_r != 4'hF) begin
			en_age_r <= en_age_r + 4'h1;
		end
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not zero outside a read answer");
	a_strobes_apart: assert property (!(wr && rd))
		else $error("write and read strobes high together");
	a_fault_pulls_low: assert property (!fault_n_oe_n |-> !fault_n_o)
		else $error("fault pin enabled but not driven low");
	a_detect_pulls_low: assert property (!detect_n_oe_n |-> !detect_n_o)
		else $error("detect pin enabled but not driven low");
	a_read_clears_fault: assert property (status_rd |=> fault_n_oe_n)
		else $error("fault pin still low after status read");
	a_fault_flag_read: assert property (status_rd && !fault_n_oe_n |=> rdata[3] == 1'b1)
		else $error("status read misses a pending fault");
	a_fault_sticky: assert property ($rose(fault_n_oe_n) |-> $past(status_rd) || en_age_r < 4'h8)
		else $error("fault released without a clearing action");
	a_ctl_low_zero: assert property (rd && addr == 8'h01 |=> rdata[3:0] == 4'h0)
		else $error("unused control bits read nonzero");
	c_fault_set: cover property ($fell(fault_n_oe_n));
	c_fault_read: cover property (status_rd && !fault_n_oe_n);
	c_detect_on: cover property ($fell(detect_n_oe_n));
endmodule : lnbc_asserts

// [sim/tb.sv]
// self-checking bench joining the device end and the host end
`timescale 1ns/1ps
module tb
	import lnbc_pkg::*;
;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic overcurrent = 1'b0;
	logic temp_high = 1'b0;
	logic temp_low = 1'b0;
	logic vout_ok = 1'b1;
	logic detect_level = 1'b0;
	logic user_enable = 1'b0;
	logic user_tone = 1'b0;
	logic [7:0] user_addr = 8'h00;
	logic [7:0] user_wdata = 8'h00;
	logic user_wr = 1'b0;
	logic user_rd = 1'b0;
	logic [7:0] user_rdata;
	logic fault_seen;
	logic tone_present;
	logic dish_supply_on;
	logic tone_drive;
	logic switch_limit_scale_sel;
	logic [7:0] rv;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;
	always #12.5 sys_clk = ~sys_clk;
	// ----------------------------------------------------------------
	// the two ends and the checker
	// ----------------------------------------------------------------
	lnbc_if lnk ();
	// short hiccup counts keep the run brief: tick 4 cycles, on 3/6, off 10/20 ticks
	lnbc_device #(.ON_SHORT_TICKS(3), .ON_LONG_TICKS(6), .OFF_SHORT_TICKS(10), .OFF_LONG_TICKS(20),
		.TICK_CYC(4)) lnbc_device_i (.sys_clk(sys_clk), .arst_n(arst_n), .lnk(lnk),
		.overcurrent_in(overcurrent), .temp_high_in(temp_high), .temp_low_in(temp_low),
		.output_voltage_ok_in(vout_ok), .detect_in(detect_level), .dish_supply_on(dish_supply_on),
		.tone_drive(tone_drive), .switch_limit_scale_sel(switch_limit_scale_sel));
	lnbc_host lnbc_host_i (.sys_clk(sys_clk), .arst_n(arst_n), .lnk(lnk), .user_enable(user_enable),
		.user_tone(user_tone), .user_addr(user_addr), .user_wdata(user_wdata), .user_wr(user_wr),
		.user_rd(user_rd), .user_rdata(user_rdata), .fault_seen(fault_seen), .tone_present(tone_present));
	lnbc_asserts lnbc_asserts_i (.sys_clk(sys_clk), .arst_n(arst_n), .enable_pin(lnk.enable_pin),
		.fault_n_o(lnk.fault_n_o), .fault_n_oe_n(lnk.fault_n_oe_n), .detect_n_o(lnk.detect_n_o),
		.detect_n_oe_n(lnk.detect_n_oe_n), .addr(lnk.addr), .wr(lnk.wr), .rd(lnk.rd), .rdata(lnk.rdata));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic end_sim;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_range(input string what, input int lo, input int hi, input int got);
		checks_done++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : chk_range
	// ends just past an edge so outputs have settled when sampled
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		user_addr <= a;
		user_wdata <= d;
		user_wr <= 1'b1;
		@(posedge sys_clk);
		user_wr <= 1'b0;
		cyc(3);
	endtask : reg_wr
	// host forwards one cycle late, device answers one later, host registers it once more
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		user_addr <= a;
		user_rd <= 1'b1;
		@(posedge sys_clk);
		user_rd <= 1'b0;
		cyc(2);
		d = user_rdata;
	endtask : reg_rd
	task automatic set_enable(input logic v);
		@(posedge sys_clk);
		user_enable <= v;
		cyc(8);
	endtask : set_enable
	// counts output tone edges; a nonzero half period also toggles the gate pin
	task automatic tone_edges(input int half, input int win, output int cnt);
		logic last;
		cnt = 0;
		last = tone_drive;
		for (int i = 0; i < win; i++) begin
			@(posedge sys_clk);
			if (half > 0 && i % half == 0) user_tone <= ~user_tone;
			#1;
			if (tone_drive !== last) cnt++;
			last = tone_drive;
		end
	endtask : tone_edges
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_vals;
		reg_rd(8'h01, rv);
		chk("control_one reset", 8'h00, rv);
		reg_rd(8'h02, rv);
		chk("enable bit reset", 8'h01, {7'h00, rv[7]});
		chk("voltage ok flag", 8'h01, {7'h00, rv[0]});
		reg_rd(8'h03, rv);
		chk("unmapped read", 8'h00, rv);
		chk("scale sel reset", 8'h00, {7'h00, switch_limit_scale_sel});
	endtask : t_reset_vals
	task automatic t_pin_enable;
		set_enable(1'b1);
		chk("supply on by pin", 8'h01, {7'h00, dish_supply_on});
		set_enable(1'b0);
		chk("supply off by pin", 8'h00, {7'h00, dish_supply_on});
		reg_wr(8'h01, 8'h20);
		reg_rd(8'h01, rv);
		chk("control_one with pin low", 8'h20, rv);
		chk("scale sel set", 8'h01, {7'h00, switch_limit_scale_sel});
		reg_wr(8'h01, 8'h00);
	endtask : t_pin_enable
	task automatic t_bus_control;
		reg_wr(8'h01, 8'h80);
		chk("supply on by bit", 8'h01, {7'h00, dish_supply_on});
		reg_wr(8'h02, 8'h00);
		chk("supply off by bit", 8'h00, {7'h00, dish_supply_on});
		reg_wr(8'h02, 8'h80);
		chk("supply on again", 8'h01, {7'h00, dish_supply_on});
		reg_wr(8'h01, 8'h00);
		chk("pin back in charge", 8'h00, {7'h00, dish_supply_on});
	endtask : t_bus_control
	// windows allow one tick of phase plus the input synchroniser
	task automatic t_hiccup(input logic long_sel);
		int on_c;
		int off_c;
		on_c = long_sel ? 24 : 12;
		off_c = long_sel ? 80 : 40;
		reg_wr(8'h01, {1'b0, long_sel, 6'h00});
		set_enable(1'b1);
		@(posedge sys_clk);
		overcurrent <= 1'b1;
		n = 0;
		while (dish_supply_on === 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
		chk_range("clamp time", on_c - 4, on_c + 8, n);
		n = 0;
		while (dish_supply_on !== 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
		chk_range("off time", off_c - 5, off_c + 5, n);
		n = 0;
		while (dish_supply_on === 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
		chk_range("retry clamp", on_c - 5, on_c + 5, n);
		chk("fault seen", 8'h01, {7'h00, fault_seen});
		@(posedge sys_clk);
		overcurrent <= 1'b0;
		cyc(120);
		chk("fault held", 8'h00, {7'h00, lnk.fault_n_oe_n});
		reg_rd(8'h02, rv);
		chk("fault and current flags", 8'h05, {6'h00, rv[1], 1'b0, rv[3]});
		chk("fault released by read", 8'h01, {7'h00, lnk.fault_n_oe_n});
		reg_wr(8'h01, 8'h00);
	endtask : t_hiccup
	task automatic t_thermal;
		@(posedge sys_clk);
		temp_high <= 1'b1;
		temp_low <= 1'b1;
		cyc(8);
		chk("off when hot", 8'h00, {7'h00, dish_supply_on});
		chk("thermal fault", 8'h01, {7'h00, fault_seen});
		reg_rd(8'h01, rv);
		chk("bus live when hot", 8'h00, rv);
		@(posedge sys_clk);
		temp_high <= 1'b0;
		cyc(8);
		chk("off in hysteresis", 8'h00, {7'h00, dish_supply_on});
		@(posedge sys_clk);
		temp_low <= 1'b0;
		cyc(8);
		chk("on when cooled", 8'h01, {7'h00, dish_supply_on});
		set_enable(1'b0);
		chk("fault held pin low", 8'h01, {7'h00, fault_seen});
		set_enable(1'b1);
		chk("fault cleared by pin", 8'h00, {7'h00, fault_seen});
	endtask : t_thermal
	task automatic t_tone;
		@(posedge sys_clk);
		user_tone <= 1'b1;
		cyc(20);
		tone_edges(0, 4000, n);
		chk_range("internal tone edges", 3, 6, n);
		@(posedge sys_clk);
		user_tone <= 1'b0;
		cyc(2000);
		tone_edges(0, 4000, n);
		chk_range("gated off edges", 0, 0, n);
		tone_edges(909, 8000, n);
		chk_range("external tone edges", 6, 10, n);
		@(posedge sys_clk);
		user_tone <= 1'b0;
		reg_wr(8'h01, 8'h10);
		tone_edges(455, 8000, n);
		chk_range("double rate edges", 14, 19, n);
		@(posedge sys_clk);
		user_tone <= 1'b0;
		reg_wr(8'h01, 8'h00);
	endtask : t_tone
	task automatic t_detect;
		@(posedge sys_clk);
		detect_level <= 1'b1;
		cyc(LNBC_DET_WINDOW_CYC / 2);
		chk("detect follows start", 8'h00, {7'h00, lnk.detect_n_oe_n});
		repeat (4) begin
			repeat (909) @(posedge sys_clk);
			detect_level <= ~detect_level;
		end
		cyc(10);
		chk("tone present", 8'h01, {7'h00, tone_present});
		cyc(LNBC_DET_WINDOW_CYC - 200);
		chk("detect held", 8'h00, {7'h00, lnk.detect_n_oe_n});
		cyc(300);
		chk("detect released", 8'h01, {7'h00, lnk.detect_n_oe_n});
	endtask : t_detect
	// ----------------------------------------------------------------
	// main sequence and hang guard
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 70000) begin
			miscompares++;
			$display("Error timeout expected end seen %0d cycles", cycles);
			end_sim();
		end
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		cyc(2);
		t_reset_vals();
		t_pin_enable();
		t_bus_control();
		t_hiccup(1'b0);
		t_hiccup(1'b1);
		t_thermal();
		t_tone();
		t_detect();
		end_sim();
	end
endmodule : tb
